// >>> rtl/i2c_status_top.sv
/*
 * Two-wire bus status flags, slave address matching with bit masking,
 * a single-byte master transmit sequence, and an APB register slave.
 * Assumes an APB master on clk_i and open-drain bus pins outside.
 */
// Added by the designer: the address map and the APB interface to the registers.
// Summary of operation
// - at each acknowledge slot end, flag shows NACK as 1, ACK as 0
// - master transmit flag set at start, cleared after the acknowledge slot, ACK or NACK, or on collision
// - collision during master operation sets a flag only software clears
// - general call match sets a flag; Stop clears it
// - second byte of matching ten-bit address sets a flag; Stop clears it
// - transmit buffer write while busy is rejected and sets sticky flag
// - byte arriving while receive buffer is unread sets sticky overflow flag
// - slave address match clears data flag; data byte or send sets it
// - stop flag reads 1 when the last bus condition was a Stop
// - start flag reads 1 after Start or Repeated Start; Stop clears it
// - after slave address byte, direction flag shows read 1, write 0
// - receive full set when byte enters receive buffer; read clears
// - transmit full set on buffer write; cleared when sending completes
// - each set mask bit makes that address bit position don't-care
// - status bits 13 to 11 read zero and ignore writes
// - reserved bus addresses never match in seven-bit mode without IPMI, whatever the mask, except an enabled general call
// - general call is acknowledged only when enabled
`timescale 1ns/1ps
`include "i2c_status_map.svh"
module i2c_status_top #(
   parameter int QTR_CYCLES = `QTR_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   import i2c_status_pkg::*;
   bus_mon_if mon_if ();
   bus_monitor u_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .mon(mon_if.mon)
   );
   eng_t q;
   eng_t n;
   logic setup;
   logic acc;
   logic mapped;
   logic mst;
   logic busy;
   logic tick;
   logic [15:0] status;

   function automatic logic masked_eq(input logic [9:0] a, input logic [9:0] b,
                                      input logic [9:0] m);
      masked_eq = (((a ^ b) & ~m) == 10'h000);
   endfunction
   function automatic logic reserved7(input logic [6:0] a);
      reserved7 = (a[6:3] == 4'h0) || (a[6:3] == 4'hF);
   endfunction
   assign setup = psel_i & ~penable_i;
   assign acc = psel_i & penable_i;
   assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `OFS_RX);
   assign mst = q.st inside {ST_MSTART, ST_MBIT, ST_MACK, ST_MSTOP};
   assign busy = mst || (q.st == ST_STX);
   assign tick = (q.qcnt == 16'(QTR_CYCLES - 1));
   assign status = {q.ack_result_flag, q.master_tx_active, 3'b000, q.bus_collision_flag, q.general_call_seen, q.ten_bit_match_flag, q.write_collision_flag, q.ov,
                    q.da, q.p, q.s, q.rw, q.receive_full_flag, q.transmit_full_flag};

   always_comb begin
      n = q;
      // Read data is captured in the setup cycle
      if (setup) begin
         unique case (paddr_i)
            `OFS_STATUS: n.rdata = status;
            `OFS_MASK: n.rdata = {6'h00, q.msk};
            `OFS_CTRL: n.rdata = {11'h000, q.ctrl};
            `OFS_OWN: n.rdata = {6'h00, q.own};
            `OFS_TX: n.rdata = {8'h00, q.tbuf};
            `OFS_RX: n.rdata = {8'h00, q.rbuf};
            default: n.rdata = 16'h0000;
         endcase
      end
      // Software writes and clears come first so hardware sets win
      if (acc && pwrite_i) begin
         unique case (paddr_i)
            `OFS_STATUS: begin
               n.bus_collision_flag = q.bus_collision_flag & pwdata_i[`ST_BCL_BIT];
               n.write_collision_flag = q.write_collision_flag & pwdata_i[`ST_WRITE_COLLISION_FLAG_BIT];
               n.ov = q.ov & pwdata_i[`ST_OV_BIT];
            end
            `OFS_MASK: n.msk = pwdata_i[9:0];
            `OFS_CTRL: n.ctrl = pwdata_i[4:0];
            `OFS_OWN: n.own = pwdata_i[9:0];
            `OFS_TX: begin
               if (busy) begin
                  n.write_collision_flag = 1'b1;
               end else begin
                  n.tbuf = pwdata_i[7:0];
                  n.transmit_full_flag = 1'b1;
                  if (q.ctrl[`CTL_MST_BIT] && q.ctrl[`CTL_EN_BIT]) begin
                     if (q.s) begin
                        n.bus_collision_flag = 1'b1;
                     end else if (q.st == ST_IDLE) begin
                        n.st = ST_MSTART;
                        n.ph = 2'd0;
                        n.qcnt = 16'h0000;
                        n.sh = pwdata_i[7:0];
                        n.cnt = 4'd0;
                        n.master_tx_active = 1'b1;
                     end
                  end
               end
            end
            default: ;
         endcase
      end
      if (acc && !pwrite_i && paddr_i == `OFS_RX) begin
         n.receive_full_flag = 1'b0;
      end
      // Bus conditions
      if (mon_if.start) begin
         n.s = 1'b1;
         n.p = 1'b0;
         if (!mst && q.ctrl[`CTL_EN_BIT]) begin
            n.st = ST_RX;
            n.cnt = 4'd0;
            n.addr_ph = 1'b1;
         end
      end
      if (mon_if.stop) begin
         n.p = 1'b1;
         n.s = 1'b0;
         n.general_call_seen = 1'b0;
         n.ten_bit_match_flag = 1'b0;
         n.ten_hi = 1'b0;
         if (!mst) begin
            n.st = ST_IDLE;
         end
      end
      if (mst) begin
         n.qcnt = tick ? 16'h0000 : q.qcnt + 16'h0001;
      end
      unique case (q.st)
         ST_IDLE: ;
         ST_RX: begin
            if (mon_if.scl_rise && q.cnt != 4'd8) begin
               n.sh = {q.sh[6:0], mon_if.sda};
               n.cnt = q.cnt + 4'd1;
            end else if (mon_if.scl_fall && q.cnt == 4'd8) begin
               n.st = ST_IDLE;
               n.addr_ph = 1'b0;
               n.ack_drv = 1'b0;
               n.is_read = 1'b0;
               if (q.addr_ph) begin
                  if (q.ctrl[`CTL_A10M_BIT]) begin
                     if (q.sh[7:3] == 5'b11110 &&
                         masked_eq({8'h00, q.sh[2:1]}, {8'h00, q.own[9:8]},
                                   {8'h00, q.msk[9:8]})) begin
                        if (!q.sh[0]) begin
                           n.ten_hi = 1'b1;
                           n.ack_drv = 1'b1;
                        end else if (q.ten_bit_match_flag) begin
                           n.ack_drv = 1'b1;
                           n.is_read = 1'b1;
                        end
                     end
                  end else if (q.sh == 8'h00) begin
                     n.ack_drv = q.ctrl[`CTL_GENERAL_CALL_ENABLE_BIT];
                     n.general_call_seen = q.ctrl[`CTL_GENERAL_CALL_ENABLE_BIT];
                  end else if (q.ctrl[`CTL_IPMI_BIT]) begin
                     n.ack_drv = 1'b1;
                     n.is_read = q.sh[0];
                  end else if (!reserved7(q.sh[7:1]) &&
                               masked_eq({3'h0, q.sh[7:1]}, {3'h0, q.own[6:0]},
                                         {3'h0, q.msk[6:0]})) begin
                     n.ack_drv = 1'b1;
                     n.is_read = q.sh[0];
                  end
                  if (n.ack_drv) begin
                     n.st = ST_ACK;
                     n.da = 1'b0;
                     n.rw = q.sh[0];
                  end
               end else if (q.ten_hi) begin
                  n.ten_hi = 1'b0;
                  if (masked_eq({2'h0, q.sh}, {2'h0, q.own[7:0]},
                                {2'h0, q.msk[7:0]})) begin
                     n.st = ST_ACK;
                     n.ack_drv = 1'b1;
                     n.ten_bit_match_flag = 1'b1;
                     n.da = 1'b0;
                     n.rw = 1'b0;
                  end
               end else begin
                  n.st = ST_ACK;
                  n.da = 1'b1;
                  if (q.receive_full_flag) begin
                     n.ov = 1'b1;
                  end else begin
                     n.rbuf = q.sh;
                     n.receive_full_flag = 1'b1;
                     n.ack_drv = 1'b1;
                  end
               end
            end
         end
         ST_ACK: begin
            if (mon_if.scl_rise) begin
               n.ack_smp = mon_if.sda;
            end else if (mon_if.scl_fall) begin
               n.ack_result_flag = q.ack_smp;
               n.ack_drv = 1'b0;
               n.cnt = 4'd0;
               if (q.is_read && !q.ack_smp) begin
                  n.st = ST_STX;
                  n.sh = q.tbuf;
               end else begin
                  n.st = q.is_read ? ST_IDLE : ST_RX;
               end
            end
         end
         ST_STX: begin
            if (mon_if.scl_fall) begin
               n.sh = {q.sh[6:0], 1'b1};
               n.cnt = q.cnt + 4'd1;
               if (q.cnt == 4'd7) begin
                  n.st = ST_ACK;
                  n.transmit_full_flag = 1'b0;
                  n.da = 1'b1;
               end
            end
         end
         ST_MSTART: begin
            if (tick) begin
               n.ph = q.ph + 2'd1;
               if (q.ph == 2'd0 && !mon_if.sda) begin
                  n.bus_collision_flag = 1'b1;
                  n.master_tx_active = 1'b0;
                  n.st = ST_IDLE;
               end else if (q.ph == 2'd3) begin
                  n.st = ST_MBIT;
               end
            end
         end
         ST_MBIT: begin
            if (tick) begin
               n.ph = q.ph + 2'd1;
               if (q.ph == 2'd2 && !q.sda_low && !mon_if.sda) begin
                  n.bus_collision_flag = 1'b1;
                  n.master_tx_active = 1'b0;
                  n.st = ST_IDLE;
               end else if (q.ph == 2'd3) begin
                  n.sh = {q.sh[6:0], 1'b1};
                  n.cnt = q.cnt + 4'd1;
                  if (q.cnt == 4'd7) begin
                     n.st = ST_MACK;
                  end
               end
            end
         end
         ST_MACK: begin
            if (tick) begin
               n.ph = q.ph + 2'd1;
               if (q.ph == 2'd2) begin
                  n.ack_smp = mon_if.sda;
               end else if (q.ph == 2'd3) begin
                  n.ack_result_flag = q.ack_smp;
                  n.master_tx_active = 1'b0;
                  n.transmit_full_flag = 1'b0;
                  n.st = ST_MSTOP;
               end
            end
         end
         ST_MSTOP: begin
            if (tick) begin
               n.ph = q.ph + 2'd1;
               if (q.ph == 2'd3) begin
                  n.st = ST_IDLE;
               end
            end
         end
      endcase
      // Pin drives follow the next state
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
      unique case (n.st)
         ST_ACK: n.sda_low = n.ack_drv;
         ST_STX: n.sda_low = ~n.sh[7];
         ST_MSTART: begin
            n.sda_low = (n.ph != 2'd0);
            n.scl_low = (n.ph == 2'd3);
         end
         ST_MBIT: begin
            n.sda_low = ~n.sh[7];
            n.scl_low = (n.ph == 2'd0) || (n.ph == 2'd3);
         end
         ST_MACK: n.scl_low = (n.ph == 2'd0) || (n.ph == 2'd3);
         ST_MSTOP: begin
            n.sda_low = (n.ph < 2'd2);
            n.scl_low = (n.ph == 2'd0);
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{st: ST_IDLE, msk: `MASK_RST, ctrl: `CTRL_RST, own: `OWN_RST,
                default: '0};
      end else begin
         q <= n;
      end
   end
   assign prdata_o = {16'h0000, q.rdata};
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~mapped;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = q.scl_low;
   assign sda_oe_o = q.sda_low;
endmodule

// >>> rtl/i2c_status_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * two-wire bus status and address-mask block.
 * Assumes a 25 MHz module clock and a byte-addressed APB with 32-bit data.
 */
`ifndef I2C_STATUS_MAP_SVH
`define I2C_STATUS_MAP_SVH

// APB byte offsets
`define OFS_STATUS 8'h00
`define OFS_MASK 8'h04
`define OFS_CTRL 8'h08
`define OFS_OWN 8'h0C
`define OFS_TX 8'h10
`define OFS_RX 8'h14

// Status field positions
`define ST_ACK_BIT 15
`define ST_MASTER_TX_ACTIVE_BIT 14
`define ST_BCL_BIT 10
`define ST_GC_BIT 9
`define ST_TEN_BIT_MATCH_FLAG_BIT 8
`define ST_WRITE_COLLISION_FLAG_BIT 7
`define ST_OV_BIT 6
`define ST_DA_BIT 5
`define ST_P_BIT 4
`define ST_S_BIT 3
`define ST_RW_BIT 2
`define ST_RBF_BIT 1
`define ST_TBF_BIT 0

// Control field positions
`define CTL_EN_BIT 0
`define CTL_GENERAL_CALL_ENABLE_BIT 1
`define CTL_A10M_BIT 2
`define CTL_IPMI_BIT 3
`define CTL_MST_BIT 4

// Reset values
`define MASK_RST 10'h000
`define CTRL_RST 5'h00
`define OWN_RST 10'h000

// Master timing: a quarter of a 100 kHz bit, least time rounded up
`define CLK_PERIOD_NS 40
`define QTR_NS 2500
`define QTR_CYC ((`QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/i2c_status_pkg.sv
/*
 * Types shared by the bus monitor and the status engine.
 * Assumes nothing of its surroundings.
 */
package i2c_status_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_STX, ST_MSTART, ST_MBIT, ST_MACK, ST_MSTOP
   } eng_state_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_p;
      logic sda_s1;
      logic sda_s2;
      logic sda_p;
   } mon_t;

   typedef struct packed {
      eng_state_t st;
      logic [3:0] cnt;
      logic [1:0] ph;
      logic [15:0] qcnt;
      logic [7:0] sh;
      logic addr_ph;
      logic ten_hi;
      logic ack_drv;
      logic ack_smp;
      logic is_read;
      logic sda_low;
      logic scl_low;
      logic [7:0] tbuf;
      logic [7:0] rbuf;
      logic [9:0] msk;
      logic [9:0] own;
      logic [4:0] ctrl;
      logic ack_result_flag;
      logic master_tx_active;
      logic bus_collision_flag;
      logic general_call_seen;
      logic ten_bit_match_flag;
      logic write_collision_flag;
      logic ov;
      logic da;
      logic p;
      logic s;
      logic rw;
      logic receive_full_flag;
      logic transmit_full_flag;
      logic [15:0] rdata;
   } eng_t;

endpackage

// >>> rtl/bus_mon_if.sv
/*
 * Carrier of synchronised bus levels and detected bus events.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ps
interface bus_mon_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport mon (output scl, sda, scl_rise, scl_fall, start, stop);
   modport eng (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// >>> rtl/bus_monitor.sv
/*
 * Synchronises the clock and data lines and finds clock edges and
 * Start and Stop conditions.
 * Assumes raw pin levels from outside the clock domain.
 */
`timescale 1ns/1ps
module bus_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   bus_mon_if.mon mon
);
   import i2c_status_pkg::*;

   mon_t q;
   mon_t n;

   always_comb begin
      n = q;
      n.scl_s1 = scl_i;
      n.scl_s2 = q.scl_s1;
      n.scl_p = q.scl_s2;
      n.sda_s1 = sda_i;
      n.sda_s2 = q.sda_s1;
      n.sda_p = q.sda_s2;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{default: 1'b1};
      end else begin
         q <= n;
      end
   end

   // Events are read from the second stage onward only
   assign mon.scl = q.scl_s2;
   assign mon.sda = q.sda_s2;
   assign mon.scl_rise = q.scl_s2 & ~q.scl_p;
   assign mon.scl_fall = ~q.scl_s2 & q.scl_p;
   assign mon.start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
   assign mon.stop = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
endmodule

// >>> verif/i2c_status_sva.sv
/* Checker of the status block's register and pin ports.
   Assumes it is bound onto i2c_status_top, with APB on clk_i. */
`timescale 1ns/1ps
module i2c_status_sva #(
   parameter int QTR_CYCLES = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o
);
   logic [2:0] stk_q;
   logic [2:0] stk_d;
   logic st_rd;
   logic st_wr;
   assign st_rd = psel_i && penable_i && !pwrite_i && paddr_i == 8'h00;
   assign st_wr = psel_i && penable_i && pwrite_i && paddr_i == 8'h00;
   // Sticky flags seen by software, until software writes the status
   always_comb begin
      stk_d = stk_q;
      if (st_wr) begin
         stk_d = 3'h0;
      end else if (st_rd) begin
         stk_d = stk_q | {prdata_o[10], prdata_o[7], prdata_o[6]};
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stk_q <= 3'h0;
      end else begin
         stk_q <= stk_d;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rst_clear;
      $fell(rst_i) |-> prdata_o == 32'h0 && !scl_oe_o && !sda_oe_o;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("not clear after reset");
   property p_rsvd_zero;
      st_rd |-> prdata_o[31:16] == 16'h0 && prdata_o[13:11] == 3'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("status gap bits set");
   property p_mask_hi;
      psel_i && !penable_i && !pwrite_i && paddr_i == 8'h04 ##1 penable_i
         |-> prdata_o[31:10] == 22'h0;
   endproperty
   a_mask_hi: assert property (p_mask_hi) else $error("mask upper bits set");
   property p_bcl_keep;
      st_rd && stk_q[2] |-> prdata_o[10];
   endproperty
   a_bcl_keep: assert property (p_bcl_keep) else $error("collision flag lost");
   property p_write_collision_flag_keep;
      st_rd && stk_q[1] |-> prdata_o[7];
   endproperty
   a_write_collision_flag_keep: assert property (p_write_collision_flag_keep) else $error("write collision lost");
   property p_ov_keep;
      st_rd && stk_q[0] |-> prdata_o[6];
   endproperty
   a_ov_keep: assert property (p_ov_keep) else $error("overflow flag lost");
   property p_tx_pair;
      st_rd && prdata_o[14] |-> prdata_o[0];
   endproperty
   a_tx_pair: assert property (p_tx_pair) else $error("transmit without full");
   property p_cond_excl;
      st_rd |-> !(prdata_o[4] && prdata_o[3]);
   endproperty
   a_cond_excl: assert property (p_cond_excl) else $error("start and stop both set");
endmodule
bind i2c_status_top i2c_status_sva #(.QTR_CYCLES(QTR_CYCLES)) u_i2c_status_sva (.clk_i,
   .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .scl_oe_o, .sda_oe_o);

// >>> verif/i2c_bus_peer.sv
/* Behavioural bus master on the far side of the two-wire pins.
   Assumes pulled-up wires resolved by the bench; a high pull output drives low. */
`timescale 1ns/1ps
module i2c_bus_peer (
   input wire logic scl_w_i,
   input wire logic sda_w_i,
   output logic scl_pull_o,
   output logic sda_pull_o
);
   localparam time Q = 80ns;
   initial begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
   end
   task automatic start();
      #7ns;
      sda_pull_o <= 1'b1;
      #(2*Q);
      scl_pull_o <= 1'b1;
   endtask
   task automatic stop();
      sda_pull_o <= 1'b1;
      #(2*Q);
      scl_pull_o <= 1'b0;
      #(2*Q);
      sda_pull_o <= 1'b0;
      #(4*Q);
   endtask
   // Byte MSB first, then a released acknowledge slot; nack_o is its level
   task automatic xfer(input logic [7:0] d, output logic nack_o);
      for (int i = 7; i >= -1; i--) begin
         #(2*Q);
         sda_pull_o <= (i >= 0) ? ~d[i] : 1'b0;
         #Q;
         scl_pull_o <= 1'b0;
         #Q;
         nack_o = sda_w_i;
         scl_pull_o <= 1'b1;
      end
   endtask
endmodule

// >>> verif/i2c_status_and_address_mask_test.sv
/* Self-checking bench: APB master tasks, a bus peer and one task a scenario.
   Assumes the design, the peer and the bound checker are compiled first. */
`timescale 1ns/1ps
module i2c_status_and_address_mask_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
   logic scl_pull, sda_pull, scl_w, sda_w, nk, er;
   logic [31:0] rv;
   int num_errors = 0;
   int cmp_count = 0;
   always #20 clk_i = ~clk_i;
   assign scl_w = ~scl_oe_o & ~scl_pull;
   assign sda_w = ~sda_oe_o & ~sda_pull;
   i2c_status_top #(.QTR_CYCLES(4)) u_i2c_status_top (.clk_i, .rst_i, .paddr_i, .psel_i,
      .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_i(scl_w),
      .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o);
   i2c_bus_peer u_i2c_bus_peer (.scl_w_i(scl_w), .sda_w_i(sda_w), .scl_pull_o(scl_pull),
      .sda_pull_o(sda_pull));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      paddr_i <= a;
      pwrite_i <= wr;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rv = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         results();
      end
      @(posedge clk_i);
   endtask
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      apb(1'b0, 8'h00, 32'h0);
      chk("status", rv & {16'h0, m}, {16'h0, e});
   endtask
   task automatic gap();
      repeat (8) @(posedge clk_i);
   endtask
   task automatic probe(input logic [7:0] a, input logic e);
      u_i2c_bus_peer.start();
      u_i2c_bus_peer.xfer(a, nk);
      chk("addr nack", nk, e);
      u_i2c_bus_peer.stop();
   endtask
   task automatic t_regs();
      st(16'hFFFF, 16'h0000);
      apb(1'b1, 8'h04, 32'hFFFF_FFFF);
      apb(1'b0, 8'h04, 32'h0);
      chk("mask", rv, 32'h0000_03FF);
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      st(16'hFFFF, 16'h0000);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rv[30:0], er}, 32'h1);
      chk("pin drive", {scl_o, sda_o}, 32'h0);
   endtask
   task automatic t_slave();
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b1, 8'h0C, 32'h2A);
      apb(1'b1, 8'h04, 32'h1);
      u_i2c_bus_peer.start();
      gap();
      st(16'h0018, 16'h0008);
      u_i2c_bus_peer.xfer(8'h56, nk);
      chk("addr ack", nk, 1'b0);
      gap();
      st(16'h8024, 16'h0000);
      u_i2c_bus_peer.xfer(8'h5A, nk);
      gap();
      st(16'h0022, 16'h0022);
      u_i2c_bus_peer.xfer(8'h33, nk);
      chk("full nack", nk, 1'b1);
      gap();
      st(16'h8042, 16'h8042);
      apb(1'b0, 8'h14, 32'h0);
      chk("rx", rv, 32'h5A);
      st(16'h0042, 16'h0040);
      u_i2c_bus_peer.stop();
      gap();
      st(16'h0018, 16'h0010);
      apb(1'b1, 8'h00, 32'h0);
      st(16'h0040, 16'h0000);
   endtask
   task automatic t_read();
      u_i2c_bus_peer.start();
      u_i2c_bus_peer.xfer(8'h55, nk);
      gap();
      st(16'h0024, 16'h0004);
      u_i2c_bus_peer.xfer(8'hFF, nk);
      u_i2c_bus_peer.stop();
      gap();
      st(16'h0020, 16'h0020);
   endtask
   task automatic t_resv();
      apb(1'b1, 8'h04, 32'h0);
      probe(8'h56, 1'b1);
      apb(1'b1, 8'h04, 32'h3FF);
      probe(8'hF8, 1'b1);
      probe(8'h00, 1'b1);
      apb(1'b1, 8'h08, 32'h3);
      u_i2c_bus_peer.start();
      u_i2c_bus_peer.xfer(8'h00, nk);
      chk("gc ack", nk, 1'b0);
      gap();
      st(16'h0200, 16'h0200);
      u_i2c_bus_peer.stop();
      gap();
      st(16'h0200, 16'h0000);
   endtask
   task automatic t_ten();
      apb(1'b1, 8'h08, 32'h5);
      apb(1'b1, 8'h0C, 32'h2A5);
      apb(1'b1, 8'h04, 32'h0);
      u_i2c_bus_peer.start();
      u_i2c_bus_peer.xfer(8'hF4, nk);
      chk("ten hi ack", nk, 1'b0);
      u_i2c_bus_peer.xfer(8'hA5, nk);
      chk("ten lo ack", nk, 1'b0);
      gap();
      st(16'h0120, 16'h0100);
      u_i2c_bus_peer.stop();
      gap();
      st(16'h0100, 16'h0000);
      apb(1'b1, 8'h08, 32'h9);
      probe(8'h56, 1'b0);
   endtask
   task automatic t_master();
      int n;
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h08, 32'h11);
      apb(1'b1, 8'h10, 32'hA5);
      st(16'h4001, 16'h4001);
      apb(1'b1, 8'h10, 32'h3C);
      st(16'h4081, 16'h4081);
      n = 0;
      do begin
         apb(1'b0, 8'h00, 32'h0);
         n++;
      end while (rv[14] !== 1'b0 && n < 200);
      if (n >= 200) begin
         num_errors++;
         results();
      end
      chk("tx end", {rv[15:14], rv[0]}, 3'b100);
      repeat (24) @(posedge clk_i);
      apb(1'b1, 8'h00, 32'h0);
      st(16'h0080, 16'h0000);
      u_i2c_bus_peer.start();
      gap();
      apb(1'b1, 8'h10, 32'h77);
      st(16'h0400, 16'h0400);
      u_i2c_bus_peer.stop();
      gap();
      st(16'h0400, 16'h0400);
      apb(1'b1, 8'h00, 32'h0);
      st(16'h0400, 16'h0000);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_slave();
      t_read();
      t_resv();
      t_ten();
      t_master();
      results();
   end
endmodule
